// >>> hw/wdtc_top.sv
// wdtc_top: watchdog control/status register, prescaler and counter
`timescale 1ns/1ns

// Behaviour
// R1 - run bit acts only when nv field ones
// R2 - writing one clears count, zero ignored
// R3 - clear bit reads one until clear done
// R4 - overflow sets timeout flag until software clears
// R5 - low-power run bit selects idle/power-down counting when nv field ones
// R6 - watchdog reset sets the reset-cause flag
// R7 - cause flag: power-on clears, others keep
// R8 - prescale select divides 1/1 to 1/256
// R9 - power-on sets prescale bits, others keep
// R10 - writes ignored without timed-access unlock
// R11 - software uses wake-up timer if divided
// R12 - counter ticks per prescale, wraps, overflows
module wdtc_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire wdtc_pkg::wdtc_rst_cause_t rstCause,
  input wire wdtc_pkg::wdtc_sfr_req_t sfrReq,
  input wire logic taUnlocked,
  input wire logic [3:0] nvEnableField,
  input wire logic idleMode,
  input wire logic powerDownMode,
  output logic [7:0] sfrRdata,
  output logic timeoutPulse,
  output logic wdtResetRequest
);
  import wdtc_pkg::*;

  // control fields held by software
  logic runEnable_reg;
  logic runEnable_next;
  logic lowPowerRun_reg;
  logic lowPowerRun_next;
  logic [2:0] prescaleSel_reg;
  logic [2:0] prescaleSel_next;

  // status flags set by hardware
  logic timeoutFlag_reg;
  logic timeoutFlag_next;
  logic resetCause_reg;
  logic resetCause_next;

  // clear sequencer
  wdtc_clr_state_t clrState_reg;
  wdtc_clr_state_t clrState_next;

  // prescaler and watchdog counter
  logic [7:0] preCount_reg;
  logic [7:0] preCount_next;
  logic [5:0] wdtCount_reg;
  logic [5:0] wdtCount_next;

  // registered outputs
  logic [7:0] sfrRdata_reg;
  logic [7:0] sfrRdata_next;
  logic timeoutPulse_reg;
  logic timeoutPulse_next;
  logic wdtResetRequest_reg;
  logic wdtResetRequest_next;

  // decoded helpers
  logic ctrlHit; // request targets this register
  logic ctrlWrite; // accepted write
  logic gpMode; // general purpose timer configuration
  logic lowPower; // chip in idle or power-down
  logic counting; // counter allowed to advance
  logic preTick; // prescaled counting clock pulse
  logic overflow; // counter wraps this cycle
  logic [7:0] statusByte; // live register image

  // address decode and timed-access gate
  always_comb begin
    ctrlHit = (sfrReq.addr == CTRL_ADDR);
    // a locked write is dropped silently, no error shows at the port
    ctrlWrite = sfrReq.wr && ctrlHit && taUnlocked; // R10
  end

  // mode and run decision
  always_comb begin
    // the run and low-power bits only mean something in gp configuration
    gpMode = (nvEnableField == NV_ALL_ONES); // R1
    lowPower = idleMode || powerDownMode;
    if (gpMode) begin
      // software run bit gates counting
      counting = runEnable_reg && (!lowPower || lowPowerRun_reg); // R1 R5
    end else begin
      // reset-timer configuration: always counting while awake
      counting = !lowPower;
    end
  end

  // prescaler tick and overflow detection
  always_comb begin
    // tick when the prescaler reaches the selected last count
    preTick = counting && (preCount_reg == wdtc_pre_last(prescaleSel_reg)); // R8
    overflow = preTick && (wdtCount_reg == CNT_MAX); // R12
  end

  // live image of the register as software reads it
  always_comb begin
    statusByte = 8'h00;
    statusByte[RUN_BIT] = runEnable_reg;
    // pending clear reads back as one
    statusByte[CLR_BIT] = (clrState_reg == CLR_BUSY); // R3
    statusByte[TF_BIT] = timeoutFlag_reg;
    statusByte[LP_BIT] = lowPowerRun_reg;
    statusByte[RF_BIT] = resetCause_reg;
    statusByte[PS_LSB +: PS_W] = prescaleSel_reg;
  end

  // next values of the software control fields
  always_comb begin
    runEnable_next = runEnable_reg;
    lowPowerRun_next = lowPowerRun_reg;
    prescaleSel_next = prescaleSel_reg;
    if (!rst_n) begin
      // run and low-power bits return to off on every reset
      runEnable_next = RUN_RESET;
      lowPowerRun_next = LP_RESET;
      if (rstCause.powerOn) begin
        // only power-on restores the slowest prescale
        prescaleSel_next = PS_POR_RESET; // R9
      end
    end else if (ctrlWrite) begin
      runEnable_next = sfrReq.wdata[RUN_BIT]; // R1
      lowPowerRun_next = sfrReq.wdata[LP_BIT]; // R5
      prescaleSel_next = sfrReq.wdata[PS_LSB +: PS_W]; // R8
    end
  end

  // next values of the hardware flags
  always_comb begin
    timeoutFlag_next = timeoutFlag_reg;
    resetCause_next = resetCause_reg;
    if (!rst_n) begin
      timeoutFlag_next = TF_RESET;
      if (rstCause.powerOn) begin
        resetCause_next = RF_POR_RESET; // R7
      end else if (rstCause.watchdog) begin
        resetCause_next = 1'h1; // R6 R7
      end
    end else begin
      // software may write either flag; write zero is how it clears them
      if (ctrlWrite) begin
        timeoutFlag_next = sfrReq.wdata[TF_BIT]; // R4
        resetCause_next = sfrReq.wdata[RF_BIT]; // R6
      end
      // an overflow in the same cycle as a clearing write still lands
      if (overflow) begin
        timeoutFlag_next = 1'h1; // R4
      end
    end
  end

  // clear sequencer: one pending cycle, then counter is known zero
  always_comb begin
    clrState_next = clrState_reg;
    if (!rst_n) begin
      clrState_next = CLR_IDLE;
    end else begin
      case (clrState_reg)
        CLR_IDLE: begin
          // writing zero to the clear bit does nothing
          if (ctrlWrite && sfrReq.wdata[CLR_BIT]) begin
            clrState_next = CLR_BUSY; // R2
          end
        end
        CLR_BUSY: begin
          // counter is zeroed on this edge; pending drops with it
          clrState_next = CLR_IDLE; // R3
        end
        default: begin
          clrState_next = CLR_IDLE;
        end
      endcase
    end
  end

  // prescaler and counter next values
  always_comb begin
    preCount_next = preCount_reg;
    wdtCount_next = wdtCount_reg;
    if (!rst_n) begin
      preCount_next = PRE_ZERO;
      wdtCount_next = CNT_ZERO;
    end else if (clrState_reg == CLR_BUSY) begin
      // clear also restarts the prescaler so the first period is full
      preCount_next = PRE_ZERO; // R2
      wdtCount_next = CNT_ZERO; // R2
    end else if (preTick) begin
      preCount_next = PRE_ZERO;
      // wraps from max to zero and keeps counting
      wdtCount_next = wdtCount_reg + 6'h01; // R12
    end else if (counting) begin
      preCount_next = preCount_reg + 8'h01; // R8
    end
    // stopped: both hold, so a resume continues the same period
  end

  // read data and event outputs
  always_comb begin
    sfrRdata_next = 8'h00;
    timeoutPulse_next = 1'h0;
    wdtResetRequest_next = 1'h0;
    if (rst_n) begin
      // unmapped or idle cycles return zero
      if (sfrReq.rd && ctrlHit) begin
        sfrRdata_next = statusByte;
      end
      timeoutPulse_next = overflow;
      // only the reset-timer configuration resets the chip on overflow
      wdtResetRequest_next = overflow && !gpMode;
    end
  end

  // register stage for all state
  always_ff @(posedge core_clk) begin
    runEnable_reg <= runEnable_next;
    lowPowerRun_reg <= lowPowerRun_next;
    prescaleSel_reg <= prescaleSel_next;
    timeoutFlag_reg <= timeoutFlag_next;
    resetCause_reg <= resetCause_next;
    clrState_reg <= clrState_next;
    preCount_reg <= preCount_next;
    wdtCount_reg <= wdtCount_next;
    sfrRdata_reg <= sfrRdata_next;
    timeoutPulse_reg <= timeoutPulse_next;
    wdtResetRequest_reg <= wdtResetRequest_next;
  end

  // outputs straight from flip-flops
  assign sfrRdata = sfrRdata_reg;
  assign timeoutPulse = timeoutPulse_reg;
  assign wdtResetRequest = wdtResetRequest_reg;

endmodule : wdtc_top

// >>> hw/wdtc_pkg.sv
// wdtc_pkg: constants and carrier types for the watchdog control block
package wdtc_pkg;

  // register address on the special-function bus
  localparam logic [7:0] CTRL_ADDR = 8'haa;

  // field positions inside watchdog_control_status
  localparam int RUN_BIT = 7; // watchdog_run_enable
  localparam int CLR_BIT = 6; // watchdog_counter_clear
  localparam int TF_BIT = 5; // watchdog_timeout_flag
  localparam int LP_BIT = 4; // watchdog_run_in_low_power
  localparam int RF_BIT = 3; // watchdog_reset_cause_flag
  localparam int PS_LSB = 0; // watchdog_prescale_select low bit
  localparam int PS_W = 3; // watchdog_prescale_select width

  // reset values
  localparam logic RUN_RESET = 1'h0;
  localparam logic LP_RESET = 1'h0;
  localparam logic TF_RESET = 1'h0;
  localparam logic RF_POR_RESET = 1'h0;
  localparam logic [2:0] PS_POR_RESET = 3'h7;

  // non-volatile enable field value that selects general purpose timer use
  localparam logic [3:0] NV_ALL_ONES = 4'hf;

  // counter and prescaler sizes
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_MAX = 6'h3f;
  localparam int PRE_W = 8;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam logic [5:0] CNT_ZERO = 6'h00;

  // last prescaler count per select value: ratios 1,4,8,16,32,64,128,256
  function automatic logic [7:0] wdtc_pre_last(input logic [2:0] sel);
    logic [7:0] last;
    last = 8'hff;
    case (sel)
      3'h0: last = 8'h00;
      3'h1: last = 8'h03;
      3'h2: last = 8'h07;
      3'h3: last = 8'h0f;
      3'h4: last = 8'h1f;
      3'h5: last = 8'h3f;
      3'h6: last = 8'h7f;
      default: last = 8'hff;
    endcase
    return last;
  endfunction : wdtc_pre_last

  // one special-function bus request
  typedef struct packed {
    logic wr; // write strobe
    logic rd; // read strobe
    logic [7:0] addr; // register address
    logic [7:0] wdata; // write data
  } wdtc_sfr_req_t;

  // reset cause presented while rst_n is low
  typedef struct packed {
    logic powerOn; // reset came from power-on
    logic watchdog; // reset came from a watchdog time-out
  } wdtc_rst_cause_t;

  // clear sequencer states
  typedef enum logic [1:0] {
    CLR_IDLE = 2'b01,
    CLR_BUSY = 2'b10
  } wdtc_clr_state_t;

endpackage : wdtc_pkg

// >>> dv/wdtc_assertions.sv
// wdtc_assertions: port checks for the watchdog control block
`timescale 1ns/1ns
module wdtc_assertions import wdtc_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire wdtc_pkg::wdtc_sfr_req_t sfrReq,
  input wire logic taUnlocked,
  input wire logic [3:0] nvEnableField,
  input wire logic [7:0] sfrRdata,
  input wire logic timeoutPulse,
  input wire logic wdtResetRequest
);
  logic rdCtrl; // read of the control byte
  logic wrOpen; // write that passes the unlock
  logic [4:0] keepBits; // fields with no hardware side effect
  assign rdCtrl = sfrReq.rd && sfrReq.addr == CTRL_ADDR;
  assign wrOpen = sfrReq.wr && taUnlocked && sfrReq.addr == CTRL_ADDR;
  assign keepBits = {sfrReq.wdata[RUN_BIT], sfrReq.wdata[LP_BIT], sfrReq.wdata[2:0]};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle_zero: assert property (!rdCtrl |=> sfrRdata == 8'h00)
    else $error("read data without a read");
  a_pulse_single: assert property (timeoutPulse |=> !timeoutPulse)
    else $error("timeout pulse too long");
  a_request_needs_pulse: assert property (wdtResetRequest |-> timeoutPulse)
    else $error("chip reset without overflow");
  a_request_by_mode: assert property (timeoutPulse |->
    wdtResetRequest == ($past(nvEnableField) != NV_ALL_ONES))
    else $error("chip reset in wrong mode");
  a_flag_on_read: assert property (timeoutPulse && rdCtrl && !sfrReq.wr |=> sfrRdata[TF_BIT])
    else $error("flag clear after overflow");
  a_clear_pending: assert property (wrOpen && sfrReq.wdata[CLR_BIT] ##1 rdCtrl
    |=> sfrRdata[CLR_BIT])
    else $error("clear not pending");
  a_clear_done: assert property (wrOpen && sfrReq.wdata[CLR_BIT] ##1 rdCtrl && !sfrReq.wr
    ##1 rdCtrl |=> !sfrRdata[CLR_BIT])
    else $error("clear not finished");
  a_locked_write: assert property (rdCtrl && !sfrReq.wr ##1 rdCtrl && sfrReq.wr && !taUnlocked
    |=> sfrRdata[7] == $past(sfrRdata[7]) && sfrRdata[4:0] == $past(sfrRdata[4:0]))
    else $error("locked write took effect");
  a_write_readback: assert property (wrOpen ##1 rdCtrl && !sfrReq.wr
    |=> {sfrRdata[7], sfrRdata[4], sfrRdata[2:0]} == $past(keepBits, 2))
    else $error("written fields lost");
endmodule : wdtc_assertions

// >>> dv/wdtc_top_bench.sv
// wdtc_top_bench: directed scenarios for the watchdog control block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module wdtc_top_bench;
  import wdtc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  wdtc_rst_cause_t rstCause = 2'h2; // power-on
  wdtc_sfr_req_t sfrReq = '0;
  logic taUnlocked = 1'b0;
  logic [3:0] nvEnableField = NV_ALL_ONES; // timer mode first
  logic idleMode = 1'b0;
  logic powerDownMode = 1'b0;
  logic [7:0] sfrRdata;
  logic timeoutPulse;
  logic wdtResetRequest;
  logic [7:0] q; // byte returned by the last bus cycle
  int n; // cycles waited for an overflow
  int num_errors = 0;
  int total_checks = 0;
  always #25 core_clk = ~core_clk; // 20 MHz
  wdtc_top u_wdtc_top (.core_clk(core_clk), .rst_n(rst_n), .rstCause(rstCause),
    .sfrReq(sfrReq), .taUnlocked(taUnlocked), .nvEnableField(nvEnableField),
    .idleMode(idleMode), .powerDownMode(powerDownMode), .sfrRdata(sfrRdata),
    .timeoutPulse(timeoutPulse), .wdtResetRequest(wdtResetRequest));
  // one bus cycle from a falling edge; strobes are dropped by the next waiter
  task automatic cyc(input logic w, input logic r, input logic u, input logic [7:0] a,
    input logic [7:0] d);
    sfrReq = {w, r, a, d};
    taUnlocked = u;
    @(negedge core_clk);
    q = sfrRdata;
  endtask : cyc
  task automatic wr(input logic [7:0] d);
    cyc(1'b1, 1'b0, 1'b1, CTRL_ADDR, d);
  endtask : wr
  task automatic rd;
    cyc(1'b0, 1'b1, 1'b0, CTRL_ADDR, 8'h00);
  endtask : rd
  // bus idle, then count cycles up to an overflow pulse or the limit
  task automatic wait_to(input int lim);
    sfrReq = '0;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (timeoutPulse !== 1'b1 && n < lim);
  endtask : wait_to
  task automatic rst(input wdtc_rst_cause_t c);
    sfrReq = '0;
    rstCause = c;
    rst_n = 1'b0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
  endtask : rst
  task automatic t_access;
    rd();
    `CHK("por value", 8'h07, q)
    cyc(1'b1, 1'b1, 1'b0, CTRL_ADDR, 8'h92); // locked write
    rd();
    `CHK("locked", 8'h07, q)
    cyc(1'b1, 1'b0, 1'b1, 8'ha9, 8'h92); // neighbour address
    cyc(1'b0, 1'b1, 1'b0, 8'ha9, 8'h00);
    `CHK("other addr", 8'h00, q)
    wr(8'h92);
    rd();
    `CHK("readback", 8'h92, q)
    $display("access test done");
  endtask : t_access
  task automatic t_clear;
    wr(8'h40);
    rd();
    `CHK("clear pending", 1'b1, q[CLR_BIT])
    rd();
    `CHK("clear done", 1'b0, q[CLR_BIT])
    $display("clear test done");
  endtask : t_clear
  task automatic t_timeout;
    wr(8'h80);
    wait_to(80);
    `CHK("overflow", 1'b1, timeoutPulse)
    wait_to(80);
    `CHK("period 1/1", 64, n)
    `CHK("no chip reset", 1'b0, wdtResetRequest)
    rd(); // read in the pulse cycle
    `CHK("flag set", 1'b1, q[TF_BIT])
    wr(8'h81);
    rd();
    `CHK("flag cleared", 8'h81, q)
    wait_to(300);
    wait_to(300);
    `CHK("period 1/4", 256, n)
    $display("timeout test done");
  endtask : t_timeout
  task automatic t_low;
    wr(8'h40);
    wait_to(100);
    `CHK("run off", 100, n)
    idleMode = 1'b1;
    wr(8'h80);
    wait_to(100);
    `CHK("idle stops", 100, n)
    idleMode = 1'b0;
    powerDownMode = 1'b1;
    wr(8'h90);
    wait_to(100);
    `CHK("power-down runs", 1'b1, timeoutPulse)
    powerDownMode = 1'b0;
    $display("low power test done");
  endtask : t_low
  task automatic t_chip_reset;
    nvEnableField = 4'h0;
    wr(8'h00);
    wait_to(80);
    `CHK("chip reset", 1'b1, wdtResetRequest)
    rst(2'h1);
    rd();
    `CHK("cause set", 8'h08, q)
    rst(2'h0);
    rd();
    `CHK("cause kept", 8'h08, q)
    rst(2'h2);
    rd();
    `CHK("power-on", 8'h07, q)
    $display("reset test done");
  endtask : t_chip_reset
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // hang guard, about five times the expected run
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
  initial begin
    rst(2'h2);
    t_access();
    t_clear();
    t_timeout();
    t_low();
    t_chip_reset();
    conclude();
  end
endmodule : wdtc_top_bench
bind wdtc_top wdtc_assertions u_wdtc_assertions (.core_clk(core_clk), .rst_n(rst_n),
  .sfrReq(sfrReq), .taUnlocked(taUnlocked), .nvEnableField(nvEnableField),
  .sfrRdata(sfrRdata), .timeoutPulse(timeoutPulse), .wdtResetRequest(wdtResetRequest));
